// ===== logic/timer_a_event_oneshot.sv
// one timer a channel: event counter (with two-phase decoding and z-phase clear) and one-shot.
// assumes a single clock, axi4-lite register access, and pin inputs asynchronous to CLOCK.
//
// Notes on behaviour
// - mode field 01 selects event counter mode
// - pin counting: polarity 0 counts falling edges, 1 rising; two-phase wants 0
// - direction from software register when select 0, from direction pin when 1
// - pin-selected direction: low pin decrements, high pin increments
// - count type 0 reloads on overflow/underflow, 1 free-runs
// - quadrature select picks normal or times-four decoding, channel 3 only
// - channel 3 two-phase free-run or times-four: z-phase clears counter
// - z-phase clear needs enable bit; software preloads counter with zero
// - z-phase is an edge on interrupt pin 2, polarity from its control bit
// - z-phase clear happens on the next count source cycle after the edge
// - overflow coinciding with z-phase clear raises the request once; the queued second one is overwritten while counting stays enabled
// - one-shot runs one period per trigger, then idles
// - one-shot decrements, at zero reloads, stops and raises the request
// - trigger while running reloads the counter and counting continues
// - period is n count source cycles; zero never runs
// - one-shot starts on trigger only while start bit is set
// - one-shot stops after reaching zero or when start bit clears
// - counter reads in one-shot mode are not meaningful
// - counter write when stopped loads reload and counter; running, reload only
// - prescaled source: undivided for field 0, divide by 2n for 1 to 15
`timescale 1ns/1ps

module timer_a_event_oneshot
  import timer_a_pkg::*;
#(
  parameter bit IS_CHAN3 = 1'b1
)(
  input  wire  logic                         CLOCK,
  input  wire  logic                         RST,
  input  wire  logic [timer_a_pkg::ADDR_W-1:0] AWADDR,
  input  wire  logic                         AWVALID,
  output logic                               AWREADY,
  input  wire  logic [31:0]                  WDATA,
  input  wire  logic [3:0]                   WSTRB,
  input  wire  logic                         WVALID,
  output logic                               WREADY,
  output logic [1:0]                         BRESP,
  output logic                               BVALID,
  input  wire  logic                         BREADY,
  input  wire  logic [timer_a_pkg::ADDR_W-1:0] ARADDR,
  input  wire  logic                         ARVALID,
  output logic                               ARREADY,
  output logic [31:0]                        RDATA,
  output logic [1:0]                         RRESP,
  output logic                               RVALID,
  input  wire  logic                         RREADY,
  input  wire  logic                         CHAN_IN_PIN,
  input  wire  logic                         CHAN_OUT_PIN,
  input  wire  logic                         EXT_IRQ2_PIN,
  input  wire  logic                         SUBCLOCK_DIV32,
  input  wire  logic                         OTHER_B_OVF,
  input  wire  logic                         OTHER_A_OVF,
  output logic                               IRQ_REQ,
  output logic                               TIMER_OUT
);
  import timer_a_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                awready;
    logic                wready;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                aw_got;
    logic                w_got;
    logic [ADDR_W-1:0]   awaddr;
    logic [31:0]         wdata;
    logic [3:0]          wstrb;
    logic                arready;
    logic                rvalid;
    logic [1:0]          rresp;
    logic [31:0]         rdata;
    timer_a_mode_s       mode;
    logic [15:0]         reload;
    logic [15:0]         count;
    logic                chan_start_bit;
    logic                zphase_enable;
    logic [1:0]          trig_sel;
    logic                updown_dir;
    logic                two_phase_enable;
    logic [3:0]          prescale_field;
    logic [1:0]          csrc_sel;
    logic                edge_polarity_bit;
    oneshot_e            os_state;
    logic [1:0]          in_sync;
    logic [1:0]          dir_sync;
    logic [1:0]          z_sync;
    logic [1:0]          sub_sync;
    logic                in_d;
    logic                dir_d;
    logic                z_d;
    logic                sub_d;
    logic [2:0]          div8;
    logic [4:0]          div2n;
    logic                z_pending;
    logic                irq_again;
    logic                irq;
    logic                tout;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  // byte-lane merge for the low half word
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  st);
    logic [15:0] r;
    r = old;
    if (st[0])
      r[7:0] = d[7:0];
    if (st[1])
      r[15:8] = d[15:8];
    return r;
  endfunction : merge16

  function automatic logic known_addr(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_MODE, OFS_COUNT, OFS_START, OFS_ONESHOT, OFS_TRIGSEL,
      OFS_UPDOWN, OFS_PRESCALE, OFS_IRQ2CTRL, OFS_STATUS: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : known_addr

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic        a, a_p, b, b_p;
    logic        pin_edge, src_evt, two_phase, quad4, step, up;
    logic        cs_tick, div2n_last, evt_active, running, os_trig;
    logic        ovf, z_edge, zp_allow, z_clear;
    logic [15:0] wr16;
    a = 1'b0; a_p = 1'b0; b = 1'b0; b_p = 1'b0;
    pin_edge = 1'b0; src_evt = 1'b0; two_phase = 1'b0; quad4 = 1'b0;
    step = 1'b0; up = 1'b0; cs_tick = 1'b0; div2n_last = 1'b0;
    evt_active = 1'b0; running = 1'b0; os_trig = 1'b0;
    ovf = 1'b0; z_edge = 1'b0; zp_allow = 1'b0; z_clear = 1'b0;
    wr16 = CNT_ZERO;
    s_nxt = s_r;
    s_nxt.irq = s_r.irq_again;
    s_nxt.irq_again = 1'b0;

    // two-flop synchronisers; only the second stage is looked at
    s_nxt.in_sync  = {s_r.in_sync[0], CHAN_IN_PIN};
    s_nxt.dir_sync = {s_r.dir_sync[0], CHAN_OUT_PIN};
    s_nxt.z_sync   = {s_r.z_sync[0], EXT_IRQ2_PIN};
    s_nxt.sub_sync = {s_r.sub_sync[0], SUBCLOCK_DIV32};
    s_nxt.in_d  = s_r.in_sync[1];
    s_nxt.dir_d = s_r.dir_sync[1];
    s_nxt.z_d   = s_r.z_sync[1];
    s_nxt.sub_d = s_r.sub_sync[1];
    a   = s_r.in_sync[1];
    a_p = s_r.in_d;
    b   = s_r.dir_sync[1];
    b_p = s_r.dir_d;

    // ---------------------------------------------------------------
    // count source
    // ---------------------------------------------------------------
    s_nxt.div8 = s_r.div8 + 3'h1;
    div2n_last = (s_r.div2n >= ({s_r.prescale_field, 1'b0} - 5'h01)) ||
                 (s_r.prescale_field == 4'h0);
    s_nxt.div2n = div2n_last ? 5'h00 : s_r.div2n + 5'h01;
    case (s_r.csrc_sel)
      CSRC_F1:  cs_tick = 1'b1;
      CSRC_F8:  cs_tick = (s_r.div8 == DIV8_LAST);
      CSRC_PRESCALED: cs_tick = div2n_last;
      default:  cs_tick = s_r.sub_sync[1] && !s_r.sub_d;
    endcase

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    if (AWVALID && s_r.awready)
    begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = AWADDR;
    end
    if (WVALID && s_r.wready)
    begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = WDATA;
      s_nxt.wstrb = WSTRB;
    end
    running = (s_r.mode.op_mode == OPM_EVENT && s_r.chan_start_bit) ||
              (s_r.mode.op_mode == OPM_ONESHOT && s_r.os_state == OS_RUN);
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid)
    begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = known_addr(s_r.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (s_r.wstrb[0])
      begin
        case (s_r.awaddr)
          OFS_MODE:     s_nxt.mode = timer_a_mode_s'(s_r.wdata[7:0]);
          OFS_START:    s_nxt.chan_start_bit = s_r.wdata[START_BIT];
          OFS_ONESHOT:
          begin
            os_trig = s_r.wdata[OS_START_BIT];
            s_nxt.zphase_enable = s_r.wdata[ZPH_EN_BIT];
          end
          OFS_TRIGSEL:  s_nxt.trig_sel = s_r.wdata[1:0];
          OFS_UPDOWN:
          begin
            s_nxt.updown_dir = s_r.wdata[UD_DIR_BIT];
            s_nxt.two_phase_enable = s_r.wdata[TWO_PH_BIT];
          end
          OFS_PRESCALE:
          begin
            s_nxt.prescale_field = s_r.wdata[PRE_LSB +: 4];
            s_nxt.csrc_sel = s_r.wdata[CSRC_LSB +: 2];
          end
          OFS_IRQ2CTRL: s_nxt.edge_polarity_bit = s_r.wdata[POL_BIT];
          default: ;
        endcase
      end
      if (s_r.awaddr == OFS_COUNT)
      begin
        wr16 = merge16(s_r.reload, s_r.wdata, s_r.wstrb);
        s_nxt.reload = wr16;
        if (!running)
          s_nxt.count = wr16;
      end
    end
    if (s_r.bvalid && BREADY)
      s_nxt.bvalid = 1'b0;
    s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
    s_nxt.wready  = !s_nxt.w_got && !s_nxt.bvalid;

    // ---------------------------------------------------------------
    // register reads
    // ---------------------------------------------------------------
    if (s_r.rvalid && RREADY)
      s_nxt.rvalid = 1'b0;
    if (ARVALID && s_r.arready)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = known_addr(ARADDR) ? RESP_OKAY : RESP_SLVERR;
      s_nxt.rdata  = 32'h0000_0000;
      case (ARADDR)
        OFS_MODE:     s_nxt.rdata[7:0] = s_r.mode;
        OFS_COUNT:    s_nxt.rdata[15:0] = s_r.count;   // meaningless in one-shot
        OFS_START:    s_nxt.rdata[START_BIT] = s_r.chan_start_bit;
        OFS_ONESHOT:  s_nxt.rdata[ZPH_EN_BIT] = s_r.zphase_enable;
        OFS_TRIGSEL:  s_nxt.rdata[1:0] = s_r.trig_sel;
        OFS_UPDOWN:
        begin
          s_nxt.rdata[UD_DIR_BIT] = s_r.updown_dir;
          s_nxt.rdata[TWO_PH_BIT] = s_r.two_phase_enable;
        end
        OFS_PRESCALE:
        begin
          s_nxt.rdata[PRE_LSB +: 4] = s_r.prescale_field;
          s_nxt.rdata[CSRC_LSB +: 2] = s_r.csrc_sel;
        end
        OFS_IRQ2CTRL: s_nxt.rdata[POL_BIT] = s_r.edge_polarity_bit;
        OFS_STATUS:   s_nxt.rdata[2:0] = {b, s_r.z_pending, s_r.os_state == OS_RUN};
        default: ;
      endcase
    end
    s_nxt.arready = !s_nxt.rvalid;

    // ---------------------------------------------------------------
    // event sources and direction
    // ---------------------------------------------------------------
    pin_edge = s_r.mode.count_polarity_sel ? (a && !a_p) : (!a && a_p);
    case (s_r.trig_sel)
      TRIG_PIN:     src_evt = pin_edge;
      TRIG_OTHER_B: src_evt = OTHER_B_OVF;
      default:      src_evt = OTHER_A_OVF;
    endcase
    // two-phase only counts the pins; software keeps trig_sel at 00
    two_phase = s_r.two_phase_enable && (s_r.trig_sel == TRIG_PIN);
    quad4 = two_phase && IS_CHAN3 && s_r.mode.quad_decode_sel;
    if (quad4)
    begin
      // exactly one of the two phases moved; a glitch on both is dropped
      step = (a ^ a_p) ^ (b ^ b_p);
      up   = a_p ^ b;
    end
    else if (two_phase)
    begin
      step = b && (a ^ a_p);
      up   = a;
    end
    else
    begin
      step = src_evt;
      up   = s_r.mode.updown_source_sel ? b : s_r.updown_dir;
    end

    // ---------------------------------------------------------------
    // event counter mode
    // ---------------------------------------------------------------
    evt_active = (s_r.mode.op_mode == OPM_EVENT) && s_r.chan_start_bit;
    if (evt_active && step)
    begin
      if (up)
      begin
        ovf = (s_r.count == CNT_MAX);
        s_nxt.count = ovf && !s_r.mode.count_type_sel ? s_r.reload
                                                       : s_r.count + CNT_ONE;
      end
      else
      begin
        ovf = (s_r.count == CNT_ZERO);
        s_nxt.count = ovf && !s_r.mode.count_type_sel ? s_r.reload
                                                       : s_r.count - CNT_ONE;
      end
    end

    // z-phase: edge is caught now, the clear waits for the next count source tick
    z_edge = s_r.edge_polarity_bit ? (s_r.z_sync[1] && !s_r.z_d)
                                   : (!s_r.z_sync[1] && s_r.z_d);
    zp_allow = IS_CHAN3 && evt_active && two_phase && s_r.zphase_enable &&
               (s_r.mode.count_type_sel || s_r.mode.quad_decode_sel);
    if (!zp_allow)
      s_nxt.z_pending = 1'b0;
    else
    begin
      z_clear = s_r.z_pending && cs_tick;
      if (z_clear)
      begin
        s_nxt.count = CNT_ZERO;
        s_nxt.z_pending = 1'b0;
      end
      if (z_edge)
        s_nxt.z_pending = 1'b1;
    end
    if (evt_active)
    begin
      s_nxt.irq = ovf || z_clear;
      s_nxt.irq_again = ovf && z_clear;   // second request for the coincidence
    end

    // ---------------------------------------------------------------
    // one-shot mode
    // ---------------------------------------------------------------
    os_trig = os_trig || src_evt;
    if (s_r.mode.op_mode != OPM_ONESHOT || !s_r.chan_start_bit)
      s_nxt.os_state = OS_IDLE;
    else if (os_trig && s_nxt.reload != CNT_ZERO)
    begin
      s_nxt.count = s_nxt.reload;
      s_nxt.os_state = OS_RUN;
    end
    else
    begin
      case (s_r.os_state)
        OS_IDLE: ;
        OS_RUN:
          if (cs_tick)
          begin
            if (s_r.count <= CNT_ONE)
            begin
              s_nxt.count = s_nxt.reload;
              s_nxt.os_state = OS_IDLE;
              s_nxt.irq = 1'b1;
            end
            else
              s_nxt.count = s_r.count - CNT_ONE;
          end
        default: s_nxt.os_state = OS_IDLE;
      endcase
    end
    s_nxt.tout = (s_nxt.os_state == OS_RUN);
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      s_r <= '0;
      s_r.mode <= timer_a_mode_s'(MODE_RESET);
      s_r.os_state <= OS_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  assign AWREADY   = s_r.awready;
  assign WREADY    = s_r.wready;
  assign BVALID    = s_r.bvalid;
  assign BRESP     = s_r.bresp;
  assign ARREADY   = s_r.arready;
  assign RVALID    = s_r.rvalid;
  assign RRESP     = s_r.rresp;
  assign RDATA     = s_r.rdata;
  assign IRQ_REQ   = s_r.irq;
  assign TIMER_OUT = s_r.tout;

endmodule : timer_a_event_oneshot

// ===== logic/timer_a_pkg.sv
// timer a channel: register map, mode field layout, encodings and divider constants.
// assumes a 32-bit axi4-lite slave port with byte addresses in the low eight bits.
package timer_a_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ---------------------------------------------------------------
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFS_MODE      = 8'h00;
  localparam logic [7:0]  OFS_COUNT     = 8'h04;
  localparam logic [7:0]  OFS_START     = 8'h08;
  localparam logic [7:0]  OFS_ONESHOT   = 8'h0c;
  localparam logic [7:0]  OFS_TRIGSEL   = 8'h10;
  localparam logic [7:0]  OFS_UPDOWN    = 8'h14;
  localparam logic [7:0]  OFS_PRESCALE  = 8'h18;
  localparam logic [7:0]  OFS_IRQ2CTRL  = 8'h1c;
  localparam logic [7:0]  OFS_STATUS    = 8'h20;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int          START_BIT     = 0;
  localparam int          OS_START_BIT  = 0;
  localparam int          ZPH_EN_BIT    = 1;
  localparam int          UD_DIR_BIT    = 0;
  localparam int          TWO_PH_BIT    = 1;
  localparam int          PRE_LSB       = 0;
  localparam int          CSRC_LSB      = 4;
  localparam int          POL_BIT       = 0;

  // mode register, b7 down to b0
  typedef struct packed {
    logic       quad_decode_sel;
    logic       count_type_sel;
    logic       mode_bit3;
    logic       updown_source_sel;
    logic       count_polarity_sel;
    logic       unassigned_b2;
    logic [1:0] op_mode;
  } timer_a_mode_s;

  localparam logic [7:0]  MODE_RESET    = 8'h00;
  localparam logic [1:0]  OPM_EVENT     = 2'b01;
  localparam logic [1:0]  OPM_ONESHOT   = 2'b10;

  // trigger / event source select
  localparam logic [1:0]  TRIG_PIN      = 2'b00;
  localparam logic [1:0]  TRIG_OTHER_B  = 2'b01;

  // count source select
  localparam logic [1:0]  CSRC_F1       = 2'b00;
  localparam logic [1:0]  CSRC_F8       = 2'b01;
  localparam logic [1:0]  CSRC_PRESCALED = 2'b10;
  localparam logic [2:0]  DIV8_LAST     = 3'h7;

  localparam logic [15:0] CNT_MAX       = 16'hffff;
  localparam logic [15:0] CNT_ZERO      = 16'h0000;
  localparam logic [15:0] CNT_ONE       = 16'h0001;

  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;

  typedef enum logic [1:0] {
    OS_IDLE = 2'b01,
    OS_RUN  = 2'b10
  } oneshot_e;

endpackage : timer_a_pkg

// ===== tb/timer_a_checker.sv
// checker: bus answer timing and one-shot output relations of the timer channel.
// assumes it is bound to the channel top, ports tied by name.
`timescale 1ns/1ps

module timer_a_checker (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic IRQ_REQ,
  input wire logic OTHER_B_OVF,
  input wire logic OTHER_A_OVF,
  input wire logic CHAN_IN_PIN,
  input wire logic TIMER_OUT
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);

  write_answer_a: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
    else $error("write response late");
  write_close_a: assert property (BVALID && BREADY |=> !BVALID)
    else $error("write response not withdrawn");
  write_block_a: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken while response pending");
  read_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read data late");
  read_close_a: assert property (RVALID && RREADY |=> !RVALID)
    else $error("read data not withdrawn");
  read_block_a: assert property (RVALID |-> !ARREADY)
    else $error("read taken while data pending");
  shot_stop_a: assert property ($fell(TIMER_OUT)
    |-> IRQ_REQ || BVALID || $past(BVALID) || $past(BVALID, 2))
    else $error("one-shot ended without request or stop");
  // software, other-timer or pin trigger; the pin is seen three edges late
  shot_start_a: assert property ($rose(TIMER_OUT)
    |-> BVALID || $past(BVALID) || $past(BVALID, 2) || $past(OTHER_B_OVF)
    || $past(OTHER_A_OVF) || ($past(CHAN_IN_PIN, 3) != $past(CHAN_IN_PIN, 4)))
    else $error("one-shot began without trigger");
endmodule : timer_a_checker

// ===== tb/quad_encoder_model.sv
// encoder model: quadrature phases and index pulse for the timer pins.
// assumes steps come no faster than one per six clocks.
`timescale 1ns/1ps

module quad_encoder_model (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic step,
  input  wire logic up,
  input  wire logic zreq,
  output logic      pin_a,
  output logic      pin_b,
  output logic      pin_z
);
  logic [1:0] ph_r;
  logic [2:0] z_r;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ph_r <= 2'h0;
      z_r  <= 3'h0;
    end
    else
    begin
      if (step)
        ph_r <= up ? ph_r + 2'h1 : ph_r - 2'h1;
      // six clocks, well over one count period
      z_r <= zreq ? 3'h6 : z_r - {2'h0, z_r != 3'h0};
    end
  end

  // gray order, one pin moves per step
  assign pin_a = ph_r[0] ^ ph_r[1];
  assign pin_b = ~ph_r[1];
  assign pin_z = z_r != 3'h0;
endmodule : quad_encoder_model

// ===== tb/timer_a_event_oneshot_bench.sv
// bench: register-bus sequences and encoder steps against the timer channel.
// assumes package, checker and encoder model are compiled first.
`timescale 1ns/1ps

module timer_a_event_oneshot_bench;
  import timer_a_pkg::*;

  logic        clock = 1'h0, rst = 1'h1, step = 1'h0, up = 1'h0, zreq = 1'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        ovf_b = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdat, rdata;
  logic [1:0]  bresp, rresp, resp_v;
  logic        irq, tout, awready, wready, bvalid, arready, rvalid, pin_a, pin_b, pin_z;
  int          bad_count = 0, tests_run = 0, cyc = 0, hi_n = 0, irq_n = 0, h0, i0;

  initial
  begin
    forever #5 clock = ~clock;
  end

  timer_a_event_oneshot dut (
    .CLOCK(clock), .RST(rst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .CHAN_IN_PIN(pin_a), .CHAN_OUT_PIN(pin_b), .EXT_IRQ2_PIN(pin_z),
    .SUBCLOCK_DIV32(1'h0), .OTHER_B_OVF(ovf_b), .OTHER_A_OVF(1'h0),
    .IRQ_REQ(irq), .TIMER_OUT(tout)
  );

  quad_encoder_model enc (
    .clock(clock), .rst(rst), .step(step), .up(up), .zreq(zreq),
    .pin_a(pin_a), .pin_b(pin_b), .pin_z(pin_z)
  );

  // ---------------------------------------------------------------
  // running tallies; the ceiling cuts a hang short
  // ---------------------------------------------------------------
  always @(posedge clock)
  begin
    hi_n <= hi_n + int'(tout);
    irq_n <= irq_n + int'(irq);
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    forever
    begin
      @(posedge clock);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    resp_v = bresp;
    bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    forever
    begin
      @(posedge clock);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    rdat = rdata;
    resp_v = rresp;
    rready <= 1'h0;
  endtask : rd

  task automatic steps(input int n, input logic dir);
    repeat (n)
    begin
      @(posedge clock);
      step <= 1'h1;
      up <= dir;
      @(posedge clock);
      step <= 1'h0;
      repeat (4) @(posedge clock);
    end
    repeat (8) @(posedge clock);
  endtask : steps

  task automatic zpulse();
    @(posedge clock);
    zreq <= 1'h1;
    @(posedge clock);
    zreq <= 1'h0;
    repeat (12) @(posedge clock);
  endtask : zpulse

  task automatic cnt_is(input logic [15:0] exp);
    rd(OFS_COUNT);
    chk("counter", rdat, {16'h0, exp});
  endtask : cnt_is

  // counter is loaded while stopped, then counted with start set
  task automatic ev(input logic [7:0] m, input logic [15:0] pre, input int n,
                    input logic [15:0] exp);
    wr(OFS_START, 32'h0);
    wr(OFS_COUNT, {16'h0, pre});
    wr(OFS_MODE, {24'h0, m});
    wr(OFS_START, 32'h1);
    steps(n, 1'h1);
    cnt_is(exp);
  endtask : ev

  task automatic trig(input int w);
    wr(OFS_ONESHOT, 32'h1);
    repeat (w) @(posedge clock);
  endtask : trig

  task automatic arm(input logic [31:0] c);
    wr(OFS_START, 32'h0);
    wr(OFS_COUNT, c);
    wr(OFS_START, 32'h1);
    h0 = hi_n;
    i0 = irq_n;
  endtask : arm

  initial
  begin
    repeat (10) @(posedge clock);
    rst <= 1'h0;
    repeat (3) @(posedge clock);
    rd(OFS_MODE);
    chk("mode reset", rdat, 32'h0);
    rd(8'h24);
    chk("unmapped read", {rdat[29:0], resp_v}, {30'h0, RESP_SLVERR});
    wr(8'h24, 32'h0);
    chk("unmapped write", {30'h0, resp_v}, {30'h0, RESP_SLVERR});
    wr(OFS_UPDOWN, 32'h1);
    wr(OFS_TRIGSEL, 32'h0);
    ev(8'h01, 16'h0010, 8, 16'h0012);
    ev(8'h09, 16'h0010, 1, 16'h0011);
    ev(8'h11, 16'h0010, 2, 16'h000f);
    ev(8'h01, 16'hfffe, 8, 16'hfffe);
    ev(8'h41, 16'hfffe, 8, 16'h0000);
    wr(OFS_UPDOWN, 32'h3);
    wr(OFS_IRQ2CTRL, 32'h1);
    ev(8'h91, 16'h0000, 6, 16'h0006);
    steps(2, 1'h0);
    cnt_is(16'h0004);
    wr(OFS_ONESHOT, 32'h2);
    zpulse();
    cnt_is(16'h0000);
    steps(3, 1'h1);
    wr(OFS_ONESHOT, 32'h0);
    zpulse();
    cnt_is(16'h0003);
    wr(OFS_START, 32'h0);
    wr(OFS_MODE, {30'h0, OPM_ONESHOT});
    arm(32'h3);
    trig(30);
    chk("run cycles", 32'(hi_n - h0), 32'h3);
    chk("requests", 32'(irq_n - i0), 32'h1);
    arm(32'h0);
    trig(20);
    chk("zero period", 32'(hi_n - h0), 32'h0);
    arm(32'h3);
    wr(OFS_START, 32'h0);
    trig(20);
    chk("no start", 32'(hi_n - h0), 32'h0);
    arm(32'h14);
    trig(10);
    trig(60);
    chk("retrigger", 32'(hi_n - h0 > 25), 32'h1);
    arm(32'h14);
    trig(5);
    wr(OFS_COUNT, 32'h3);
    repeat (40) @(posedge clock);
    chk("running write", 32'(hi_n - h0 > 15), 32'h1);
    h0 = hi_n;
    trig(30);
    chk("new reload", 32'(hi_n - h0), 32'h3);
    // divide by two: three ticks span five or six clocks, by divider phase
    wr(OFS_PRESCALE, 32'h21);
    arm(32'h3);
    trig(30);
    chk("prescaled run", 32'((hi_n - h0) inside {[5:6]}), 32'h1);
    wr(OFS_PRESCALE, 32'h0);
    wr(OFS_TRIGSEL, 32'h1);
    arm(32'h3);
    @(posedge clock);
    ovf_b <= 1'h1;
    @(posedge clock);
    ovf_b <= 1'h0;
    repeat (20) @(posedge clock);
    chk("timer trigger", 32'(hi_n - h0), 32'h3);
    wr(OFS_TRIGSEL, 32'h0);
    arm(32'h28);
    trig(5);
    wr(OFS_START, 32'h0);
    repeat (50) @(posedge clock);
    chk("stopped", 32'(irq_n - i0), 32'h0);
    print_verdict();
  end
endmodule : timer_a_event_oneshot_bench

bind timer_a_event_oneshot timer_a_checker chk_i (
  .CLOCK(CLOCK), .RST(RST), .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID),
  .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID),
  .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY), .IRQ_REQ(IRQ_REQ),
  .OTHER_B_OVF(OTHER_B_OVF), .OTHER_A_OVF(OTHER_A_OVF), .CHAN_IN_PIN(CHAN_IN_PIN),
  .TIMER_OUT(TIMER_OUT)
);
